// ==== tat_delay_calc.sv ====
// auto-off delay in seconds from time mode, rc/k value and multiplier
`timescale 1ns/10ps
module tat_delay_calc
  import tat_pkg::*;
(
  input  wire logic [1:0]  tmode_i,
  input  wire logic [7:0]  rck_i,
  input  wire logic        x24_i,
  output logic      [16:0] dly_o,
  output logic             inf_o
);
  logic [11:0] base;

  always_comb begin
    base  = DLY_60MIN;
    inf_o = 1'b0;
    unique case (tmode_i)
      TM_INF:   inf_o = 1'b1;
      TM_15MIN: base = DLY_15MIN;
      TM_60MIN: base = DLY_60MIN;
      TM_RC: begin
        if (rck_i < RCK_MIN) begin
          base = DLY_60MIN;
        end else if (rck_i > RCK_MAX) begin
          inf_o = 1'b1;
        end else begin
          base = {4'h0, rck_i} * RC_UNIT_S;
        end
      end
    endcase
  end

  assign dly_o = x24_i ? {5'h0, base} * MULT_LONG : {5'h0, base};
endmodule // tat_delay_calc

// ==== tat_pkg.sv ====
// shared constants for the touch auto-off timer
package tat_pkg;
  // time base
  localparam int unsigned CLK_HZ     = 250_000_000;
  localparam int unsigned TICK_MS    = 1;
  localparam int unsigned MS_CYC_DEF = CLK_HZ / 1000 * TICK_MS;
  localparam logic [9:0]  SEC_LAST   = 10'h3e7;
  // override pulse thresholds in ms
  localparam logic [6:0]  SUSTAIN_MS = 7'h19;
  localparam logic [6:0]  CANCEL_MS  = 7'h41;
  // auto-off delays in seconds
  localparam logic [11:0] DLY_15MIN  = 12'h384;
  localparam logic [11:0] DLY_60MIN  = 12'he10;
  localparam logic [11:0] RC_UNIT_S  = 12'h00f;
  localparam logic [16:0] MULT_LONG  = 17'h00018;
  localparam logic [7:0]  RCK_MIN    = 8'h04;
  localparam logic [7:0]  RCK_MAX    = 8'hf0;
  // time mode field codes
  localparam logic [1:0]  TM_INF     = 2'h0;
  localparam logic [1:0]  TM_15MIN   = 2'h1;
  localparam logic [1:0]  TM_60MIN   = 2'h2;
  localparam logic [1:0]  TM_RC      = 2'h3;
  // register map
  localparam logic [3:0]  REG_CTRL   = 4'h0;
  localparam logic [3:0]  REG_RCK    = 4'h4;
  localparam logic [3:0]  REG_STAT   = 4'h8;
  localparam logic [3:0]  REG_REMAIN = 4'hc;
  localparam int unsigned CTRL_POL   = 2;
  localparam int unsigned STAT_ON    = 0;
  localparam int unsigned STAT_X24   = 1;
  localparam int unsigned STAT_HELD  = 2;
  localparam int unsigned STAT_INF   = 3;
  localparam logic [1:0]  TMODE_RST  = 2'h0;
  localparam logic [7:0]  RCK_RST    = 8'h3c;
  // strap capture waits for the synchroniser
  localparam logic [1:0]  SYNC_SETTLE = 2'h2;

  typedef enum logic [1:0] {ST_INIT, ST_RUN, ST_HELD, ST_RECAL} tat_state_e;
endpackage

// ==== tat_sensor_model.sv ====
// board side model: acquisition end strobe and override/strap line
`timescale 1ns/10ps
module tat_sensor_model (
  // clock
  input  wire logic clk_i,
  // toward the timer
  output logic      acq_end_o,
  output logic      pin_o
);
  logic [2:0] cnt   = 3'h0;
  logic       strap = 1'b0;

  initial begin
    acq_end_o = 1'b0;
    pin_o     = 1'b0;
  end

  // one acquisition end every 8 cycles
  always @(posedge clk_i) begin
    cnt       <= cnt + 3'h1;
    acq_end_o <= (cnt == 3'h7);
  end

  // strap level through the multiplier resistor
  task automatic set_strap(input logic s);
    @(posedge clk_i);
    strap = s;
    pin_o <= s;
  endtask

  // pulse to the override level, started just after an acquisition end
  task automatic pulse(input int unsigned n);
    do @(posedge clk_i); while (acq_end_o !== 1'b1);
    pin_o <= ~strap;
    repeat (n) @(posedge clk_i);
    pin_o <= strap;
  endtask
endmodule // tat_sensor_model

// ==== tat_sync.sv ====
// two-flop synchroniser for the override line
`timescale 1ns/10ps
module tat_sync (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic meta_ff;
  logic q_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_ff <= 1'b0;
      q_ff    <= 1'b0;
    end else begin
      meta_ff <= d_i;
      q_ff    <= meta_ff;
    end
  end

  assign q_o = q_ff;
endmodule // tat_sync

// ==== tat_timer.sv ====
// touch auto-off timer with override line and wishbone registers
`timescale 1ns/10ps
module tat_timer
  import tat_pkg::*;
#(
  parameter int unsigned MS_CYC = MS_CYC_DEF
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // override line and acquisition events
  input  wire logic        override_level_input_i,
  input  wire logic        touch_i,
  input  wire logic        acq_end_i,
  // switched output and acquisition control
  output logic             out_o,
  output logic             burst_hold_o,
  output logic             recal_o
);
  localparam logic [17:0] MS_LAST = 18'(MS_CYC - 1);

  function automatic logic hit(input logic [3:0] adr, input logic [3:0] off);
    hit = (adr == off);
  endfunction

  logic        ovr_sync;
  logic        ovr_act;
  logic [16:0] dly;
  logic        dly_inf;
  logic        ms_tick;
  logic        sec_tick;

  // time base
  logic [17:0] ms_cnt_ff;
  logic [17:0] nxt_ms_cnt;
  logic [9:0]  sec_ms_ff;
  logic [9:0]  nxt_sec_ms;

  // registers and bus
  logic [1:0]  tmode_ff;
  logic [1:0]  nxt_tmode;
  logic        pol_ff;
  logic        nxt_pol;
  logic [7:0]  rck_ff;
  logic [7:0]  nxt_rck;
  logic        ack_ff;
  logic        nxt_ack;
  logic [31:0] dat_ff;
  logic [31:0] nxt_dat;
  logic        req;

  // core
  tat_state_e  st_ff;
  tat_state_e  nxt_st;
  logic        on_ff;
  logic        nxt_on;
  logic [16:0] rem_ff;
  logic [16:0] nxt_rem;
  logic [6:0]  hold_ms_ff;
  logic [6:0]  nxt_hold;
  logic [1:0]  settle_ff;
  logic [1:0]  nxt_settle;
  logic        x24_ff;
  logic        nxt_x24;
  logic        out_ff;
  logic        nxt_out;
  logic        bh_ff;
  logic        nxt_bh;
  logic        recal_ff;
  logic        nxt_recal;

  tat_sync u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (override_level_input_i),
    .q_o   (ovr_sync)
  );

  tat_delay_calc u_calc (
    .tmode_i (tmode_ff),
    .rck_i   (rck_ff),
    .x24_i   (x24_ff),
    .dly_o   (dly),
    .inf_o   (dly_inf)
  );

  // override level is the inverse of the strap level
  assign ovr_act  = ovr_sync ^ x24_ff;
  assign ms_tick  = (ms_cnt_ff == MS_LAST);
  assign sec_tick = ms_tick && (sec_ms_ff == SEC_LAST);

  always_comb begin
    nxt_ms_cnt = ms_tick ? 18'h0 : ms_cnt_ff + 18'h1;
    nxt_sec_ms = sec_ms_ff;
    if (ms_tick) begin
      nxt_sec_ms = (sec_ms_ff == SEC_LAST) ? 10'h0 : sec_ms_ff + 10'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ms_cnt_ff <= 18'h0;
      sec_ms_ff <= 10'h0;
    end else begin
      ms_cnt_ff <= nxt_ms_cnt;
      sec_ms_ff <= nxt_sec_ms;
    end
  end

  // wishbone: ack one cycle after the request, then one idle cycle
  assign req = cyc_i && stb_i && !ack_ff;

  always_comb begin
    nxt_ack   = req;
    nxt_dat   = dat_ff;
    nxt_tmode = tmode_ff;
    nxt_pol   = pol_ff;
    nxt_rck   = rck_ff;
    if (req && we_i && sel_i[0]) begin
      if (hit(adr_i, REG_CTRL)) begin
        nxt_tmode = dat_i[1:0];
        nxt_pol   = dat_i[CTRL_POL];
      end
      if (hit(adr_i, REG_RCK)) begin
        nxt_rck = dat_i[7:0];
      end
    end
    if (req && !we_i) begin
      nxt_dat = 32'h0;
      if (hit(adr_i, REG_CTRL)) begin
        nxt_dat[1:0]     = tmode_ff;
        nxt_dat[CTRL_POL] = pol_ff;
      end
      if (hit(adr_i, REG_RCK)) begin
        nxt_dat[7:0] = rck_ff;
      end
      if (hit(adr_i, REG_STAT)) begin
        nxt_dat[STAT_ON]   = on_ff;
        nxt_dat[STAT_X24]  = x24_ff;
        nxt_dat[STAT_HELD] = (st_ff == ST_HELD);
        nxt_dat[STAT_INF]  = dly_inf;
      end
      if (hit(adr_i, REG_REMAIN)) begin
        nxt_dat[16:0] = rem_ff;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff   <= 1'b0;
      dat_ff   <= 32'h0;
      tmode_ff <= TMODE_RST;
      pol_ff   <= 1'b0;
      rck_ff   <= RCK_RST;
    end else begin
      ack_ff   <= nxt_ack;
      dat_ff   <= nxt_dat;
      tmode_ff <= nxt_tmode;
      pol_ff   <= nxt_pol;
      rck_ff   <= nxt_rck;
    end
  end

  assign ack_o = ack_ff;
  assign dat_o = dat_ff;

  // core sequence
  always_comb begin
    nxt_st     = st_ff;
    nxt_on     = on_ff;
    nxt_rem    = rem_ff;
    nxt_hold   = hold_ms_ff;
    nxt_settle = settle_ff;
    nxt_x24    = x24_ff;
    unique case (st_ff)
      ST_INIT: begin
        if (settle_ff == SYNC_SETTLE) begin
          nxt_x24 = ovr_sync;
          nxt_st  = ST_RUN;
        end else begin
          nxt_settle = settle_ff + 2'h1;
        end
      end
      ST_RUN: begin
        if (touch_i) begin
          nxt_on = !on_ff;
          if (!on_ff) begin
            nxt_rem = dly;
          end
        end else if (on_ff && !dly_inf && sec_tick) begin
          if (rem_ff == 17'h1) begin
            nxt_on = 1'b0;
          end
          if (rem_ff != 17'h0) begin
            nxt_rem = rem_ff - 17'h1;
          end
        end
        // the line is only seen between bursts
        if (acq_end_i && ovr_act) begin
          nxt_st   = ST_HELD;
          nxt_hold = 7'h0;
        end
      end
      ST_HELD: begin
        if (!ovr_act) begin
          nxt_st = ST_RECAL;
        end else if (ms_tick && hold_ms_ff != CANCEL_MS) begin
          nxt_hold = hold_ms_ff + 7'h1;
          if (nxt_hold == SUSTAIN_MS && on_ff) begin
            nxt_rem = dly;
          end
          if (nxt_hold == CANCEL_MS) begin
            nxt_on = 1'b0;
          end
        end
      end
      ST_RECAL: nxt_st = ST_RUN;
    endcase
    nxt_out   = nxt_on ^ pol_ff;
    nxt_bh    = (nxt_st == ST_HELD);
    nxt_recal = (st_ff == ST_HELD) && !ovr_act;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff      <= ST_INIT;
      on_ff      <= 1'b0;
      rem_ff     <= 17'h0;
      hold_ms_ff <= 7'h0;
      settle_ff  <= 2'h0;
      x24_ff     <= 1'b0;
      out_ff     <= 1'b0;
      bh_ff      <= 1'b0;
      recal_ff   <= 1'b0;
    end else begin
      st_ff      <= nxt_st;
      on_ff      <= nxt_on;
      rem_ff     <= nxt_rem;
      hold_ms_ff <= nxt_hold;
      settle_ff  <= nxt_settle;
      x24_ff     <= nxt_x24;
      out_ff     <= nxt_out;
      bh_ff      <= nxt_bh;
      recal_ff   <= nxt_recal;
    end
  end

  assign out_o        = out_ff;
  assign burst_hold_o = bh_ff;
  assign recal_o      = recal_ff;

  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  expire_off_a: assert property (
    (st_ff == ST_RUN && !touch_i && on_ff && !dly_inf && sec_tick && rem_ff == 17'h1)
      |=> !on_ff)
    else $error("output not switched off at delay expiry");
  sustain_load_a: assert property (
    (st_ff == ST_HELD && ovr_act && ms_tick && on_ff && hold_ms_ff == SUSTAIN_MS - 7'h1)
      |=> rem_ff == $past(dly))
    else $error("sustain did not reload delay");
  cancel_off_a: assert property (
    (st_ff == ST_HELD && hold_ms_ff == CANCEL_MS) |-> !on_ff && !touch_i || !on_ff)
    else $error("cancel did not force output off");
  hold_bursts_a: assert property (
    (st_ff == ST_HELD && ovr_act) |=> st_ff == ST_HELD && burst_hold_o)
    else $error("bursts not suspended while override held");
  recal_resume_a: assert property (
    (st_ff == ST_HELD && !ovr_act)
      |=> recal_o && $stable(on_ff) ##1 st_ff == ST_RUN && !recal_o)
    else $error("no recalibration on override release");
  rc_delay_a: assert property (
    (tmode_ff == TM_RC && !x24_ff && rck_ff >= RCK_MIN && rck_ff <= RCK_MAX)
      |-> !dly_inf && dly == {9'h0, rck_ff} * {5'h0, RC_UNIT_S})
    else $error("user delay not rc/k times unit");
  range_fall_a: assert property (
    (tmode_ff == TM_RC && !x24_ff)
      |-> (rck_ff > RCK_MAX) == dly_inf
          && (rck_ff >= RCK_MIN || dly == {5'h0, DLY_60MIN}))
    else $error("out of range rc/k not mapped to fixed delay");
  long_mult_a: assert property (
    (tmode_ff == TM_15MIN && x24_ff) |-> dly == {5'h0, DLY_15MIN} * MULT_LONG)
    else $error("long multiplier not applied");
  fixed_mode_a: assert property (
    (tmode_ff == TM_60MIN && !x24_ff) |-> dly == {5'h0, DLY_60MIN} && !dly_inf)
    else $error("fixed delay wrong");
  strap_take_a: assert property (
    (st_ff == ST_INIT && settle_ff == SYNC_SETTLE)
      |=> st_ff == ST_RUN && x24_ff == $past(ovr_sync))
    else $error("multiplier strap not captured");
  acq_sample_a: assert property (
    (st_ff == ST_RUN && acq_end_i && ovr_act) |=> st_ff == ST_HELD)
    else $error("override not taken at acquisition end");
  touch_tog_a: assert property (
    (st_ff == ST_RUN && touch_i) |=> on_ff != $past(on_ff))
    else $error("touch did not toggle output");
  load_on_a: assert property (
    (st_ff == ST_RUN && touch_i && !on_ff) |=> on_ff && rem_ff == $past(dly))
    else $error("delay not loaded on switch-on");
  short_pulse_a: assert property (
    (st_ff == ST_HELD && hold_ms_ff < SUSTAIN_MS - 7'h1)
      |=> $stable(rem_ff) && $stable(on_ff))
    else $error("short override pulse had an effect");

  sustain_seen_c: cover property (st_ff == ST_HELD && hold_ms_ff == SUSTAIN_MS && on_ff);
  cancel_seen_c: cover property (st_ff == ST_HELD && hold_ms_ff == CANCEL_MS);
  expiry_seen_c: cover property (st_ff == ST_RUN && $fell(on_ff) && !$past(touch_i));
endmodule // tat_timer

// ==== tb_top.sv ====
// self-checking bench for the touch auto-off timer
`timescale 1ns/10ps
module tb_top;
  import tat_pkg::*;
  logic        clk, rst, cyc, stb, we, touch, ack, out, hold, recal, acq, pin;
  logic [3:0]  adr, sel, lanes;
  logic [31:0] wdat, rdat, q;
  int          err_count = 0;
  int          tests_run = 0;
  logic [1:0]  md [7] = '{TM_15MIN, TM_60MIN, TM_RC, TM_RC, TM_RC, TM_RC, TM_RC};
  logic [7:0]  rk [7] = '{8'h00, 8'h00, 8'h03, 8'h04, 8'h0a, 8'hf0, 8'hf1};
  logic [31:0] ex [7] = '{32'h384, 32'he10, 32'he10, 32'h3c, 32'h96, 32'he10, 32'h0};

  tat_timer #(.MS_CYC(1)) u_dut (
    .clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .override_level_input_i(pin), .touch_i(touch), .acq_end_i(acq),
    .out_o(out), .burst_hold_o(hold), .recal_o(recal));
  tat_sensor_model u_sens (.clk_i(clk), .acq_end_o(acq), .pin_o(pin));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= lanes;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    sel <= 4'h0;
    if (n >= 20) chk("ack", 32'h0, 32'h1);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e, input string nm);
    wb(1'b0, a, 32'h0);
    chk(nm, q, e);
  endtask

  task automatic tap;
    @(posedge clk) touch <= 1'b1;
    @(posedge clk) touch <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic do_reset(input logic s);
    u_sens.set_strap(s);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  // override pulse, optional touch while held, then release handshake
  task automatic ovr(input int unsigned n, input logic tap_mid);
    int k;
    k = 0;
    fork
      u_sens.pulse(n);
      begin
        repeat (20) @(posedge clk);
        chk("hold", {31'h0, hold}, 32'h1);
        if (tap_mid) tap;
      end
    join
    do begin
      @(posedge clk);
      k++;
    end while (recal !== 1'b1 && k < 12);
    chk("recal", {31'h0, recal}, 32'h1);
    chk("hold off", {31'h0, hold}, 32'h0);
  endtask

  initial begin
    rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; touch = 1'b0;
    adr = 4'h0; wdat = 32'h0;
    sel = 4'h0;
    lanes = 4'hf;
    do_reset(1'b0);
    rd(REG_CTRL, 32'h0, "ctrl");
    rd(REG_RCK, 32'h3c, "rck");
    rd(REG_STAT, 32'h8, "stat");
    rd(4'h1, 32'h0, "unmapped");
    wb(1'b1, REG_STAT, 32'hffffffff);
    rd(REG_STAT, 32'h8, "stat ro");
    $display("test registers done");
    tap;
    chk("on", {31'h0, out}, 32'h1);
    rd(REG_STAT, 32'h9, "stat inf");
    tap;
    chk("off", {31'h0, out}, 32'h0);
    for (int i = 0; i < 7; i++) begin
      wb(1'b1, REG_RCK, {24'h0, rk[i]});
      wb(1'b1, REG_CTRL, {30'h0, md[i]});
      tap;
      if (ex[i] == 32'h0) rd(REG_STAT, 32'h9, "rc inf");
      else rd(REG_REMAIN, ex[i], "delay");
      tap;
    end
    $display("test delays done");
    wb(1'b1, REG_RCK, 32'h4);
    tap;
    repeat (2500) @(posedge clk);
    // two whole seconds have passed since switch-on
    rd(REG_REMAIN, 32'h3a, "running");
    ovr(40, 1'b0);
    rd(REG_REMAIN, 32'h3c, "sustain");
    chk("kept on", {31'h0, out}, 32'h1);
    u_sens.pulse(3);
    repeat (20) @(posedge clk);
    chk("short", {31'h0, hold}, 32'h0);
    ovr(120, 1'b1);
    chk("cancel", {31'h0, out}, 32'h0);
    $display("test override done");
    // write without byte lane 0 must be ignored
    lanes = 4'he;
    wb(1'b1, REG_CTRL, 32'h7);
    lanes = 4'hf;
    rd(REG_CTRL, 32'h3, "no lane 0");
    wb(1'b1, REG_CTRL, 32'h7);
    repeat (2) @(posedge clk);
    chk("pol off", {31'h0, out}, 32'h1);
    tap;
    chk("pol on", {31'h0, out}, 32'h0);
    repeat (58500) @(posedge clk);
    chk("not yet", {31'h0, out}, 32'h0);
    repeat (2000) @(posedge clk);
    chk("expired", {31'h0, out}, 32'h1);
    $display("test expiry done");
    do_reset(1'b1);
    rd(REG_STAT, 32'ha, "x24");
    wb(1'b1, REG_RCK, 32'h4);
    wb(1'b1, REG_CTRL, 32'h3);
    tap;
    rd(REG_REMAIN, 32'h5a0, "x24 delay");
    tap;
    wb(1'b1, REG_CTRL, 32'h1);
    tap;
    rd(REG_REMAIN, 32'h5460, "x24 fixed");
    $display("test multiplier done");
    stop_test;
  end

  initial begin
    repeat (90000) @(posedge clk);
    err_count++;
    stop_test;
  end
endmodule // tb_top
